// *** cmdsel_pkg.sv ***
/*
 * Shared constants and types for the command source selector.
 * Assumes a single 20 MHz clock domain and an AXI4-Lite register port.
 */
package cmdsel_pkg;
    // Selection codes as software writes them
    localparam int SEL_W = 14;
    localparam logic [13:0] SEL_OPT = 14'h0000;
    localparam logic [13:0] SEL_CONN = 14'h0002;
    localparam logic [13:0] SEL_USB = 14'h0003;
    localparam logic [13:0] SEL_PANEL = 14'h0004;
    localparam logic [13:0] SEL_AUTO = 14'h270F;
    localparam logic [13:0] NET_SEL_RST = SEL_AUTO;
    localparam logic [13:0] LOC_SEL_RST = SEL_AUTO;
    // Build has an option slot rather than a built-in network port
    localparam logic OPT_SLOT_VARIANT = 1'h1;
    // Command ports
    localparam int NPORT = 5;
    localparam int P_PANEL = 0;
    localparam int P_PUNIT = 1;
    localparam int P_RS485 = 2;
    localparam int P_USB = 3;
    localparam int P_NET = 4;
    // One-hot command source
    localparam logic [3:0] SRC_PANEL = 4'h1;
    localparam logic [3:0] SRC_CONN = 4'h2;
    localparam logic [3:0] SRC_USB = 4'h4;
    localparam logic [3:0] SRC_NET = 4'h8;
    // Request kinds
    localparam logic [2:0] K_RUN = 3'h0;
    localparam logic [2:0] K_STOP = 3'h1;
    localparam logic [2:0] K_FREQ = 3'h2;
    localparam logic [2:0] K_PWRITE = 3'h3;
    localparam logic [2:0] K_PREAD = 3'h4;
    localparam logic [2:0] K_MON = 3'h5;
    // Register byte offsets and fields
    localparam logic [7:0] A_CFG = 8'h00;
    localparam logic [7:0] A_ACT = 8'h04;
    localparam logic [7:0] A_MODE = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0C;
    localparam logic [7:0] A_RST = 8'h10;
    localparam int F_NET_LSB = 0;
    localparam int F_LOC_LSB = 16;
    localparam int F_MODE_BIT = 0;
    localparam int F_REFUSED_BIT = 1;
    localparam int F_APPLY_BIT = 0;
    localparam int F_OPT_BIT = 4;
    localparam int F_MASK_LSB = 5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_LOCAL = 2'h1,
        ST_NET = 2'h2
    } cmdsel_mode_t;

    typedef struct packed {
        logic valid;
        logic modbus;
        logic [2:0] kind;
    } cmdsel_req_t;

    typedef struct packed {
        logic opt;
        logic usb;
        logic punit;
    } cmdsel_pins_t;
endpackage

// *** cmdsel_ports_model.sv ***
/*
 * Behavioural model of the command ports and presence pins.
 * Assumes the bench drives go/port/kind/modbus/fitted on aclk edges.
 */
`timescale 1ns/1ps
module cmdsel_ports_model
    import cmdsel_pkg::*;
(
    input wire logic aclk,
    input wire logic go,
    input wire logic [2:0] port,
    input wire logic [2:0] kind,
    input wire logic modbus,
    input wire logic [2:0] fitted,
    output cmdsel_req_t [NPORT-1:0] port_req,
    output cmdsel_pins_t pins
);
    integer i;
    initial port_req = '0;
    // One request cycle per go; idle ports toggle so stale codes never look valid
    always @(posedge aclk) begin
        for (i = 0; i < NPORT; i++) begin
            if (go && port == i) begin
                port_req[i].valid <= 1'h1;
                port_req[i].kind <= kind;
                port_req[i].modbus <= modbus;
            end else begin
                port_req[i].valid <= 1'h0;
                port_req[i].kind <= ~port_req[i].kind;
                port_req[i].modbus <= ~port_req[i].modbus;
            end
        end
    end
    // Presence levels of attached units: bit2 option, bit1 usb, bit0 param unit
    assign pins = cmdsel_pins_t'(fitted);
endmodule

// *** cmdsel_resolve.sv ***
/*
 * Combinational source resolution from latched selections and mode.
 * Assumes all inputs are registered in the aclk domain.
 */
`timescale 1ns/1ps
module cmdsel_resolve
    import cmdsel_pkg::*;
(
    input wire logic [13:0] net_sel,
    input wire logic [13:0] loc_sel,
    input wire logic in_net,
    input cmdsel_pins_t pins,
    output logic [3:0] src,
    output logic [NPORT-1:0] mask,
    output logic net_ok
);
    logic net_to_opt;

    // Network target: auto picks option when fitted (see [RULE10] [RULE11])
    always_comb begin
        if (net_sel == SEL_OPT) begin
            net_to_opt = 1'h1;
        end else if (net_sel == SEL_CONN) begin
            net_to_opt = 1'h0;
        end else begin
            net_to_opt = pins.opt;
        end
    end

    // Switch refused on double connector or missing option (see [RULE4] [RULE8])
    assign net_ok = !(net_sel == SEL_CONN && loc_sel == SEL_CONN)
        && !(OPT_SLOT_VARIANT && net_to_opt && !pins.opt);

    // Local choices among panel, connector, USB (see [RULE1] [RULE12])
    always_comb begin
        src = SRC_PANEL;
        mask = '0;
        if (in_net) begin
            if (net_to_opt) begin
                src = SRC_NET;
                mask[P_NET] = 1'h1;
            end else begin
                src = SRC_CONN;
                mask[P_RS485] = 1'h1;
            end
        end else if (loc_sel == SEL_CONN) begin
            src = SRC_CONN; // see [RULE2]
            mask[P_PUNIT] = 1'h1;
            mask[P_RS485] = 1'h1;
        end else if (loc_sel == SEL_USB) begin
            src = SRC_USB;
            mask[P_USB] = 1'h1;
        end else if (loc_sel == SEL_PANEL) begin
            mask[P_PANEL] = 1'h1;
        end else if (pins.usb) begin
            src = SRC_USB; // see [RULE9]
            mask[P_USB] = 1'h1;
        end else if (pins.punit) begin
            src = SRC_CONN; // Serial never wins here, see [RULE3]
            mask[P_PUNIT] = 1'h1;
        end else begin
            mask[P_PANEL] = 1'h1;
        end
    end
endmodule

// *** cmdsel_sync.sv ***
/*
 * Two-stage synchroniser for the presence pins.
 * Assumes inputs are asynchronous levels; only q is read downstream.
 */
`timescale 1ns/1ps
module cmdsel_sync #(
    parameter int W = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// *** cmdsel_top.sv ***
/*
 * Command source selector: AXI4-Lite registers, latched selections,
 * operation-mode state and per-port command gating.
 * Assumes command ports run on aclk; presence pins are asynchronous.
 */
// Our own choices: the address map and the AXI4-Lite interface to the registers.
// How it works
// [RULE1] Local mode may take commands from panel, connector, network port or USB; the code never makes the network port the source in local mode.
// [RULE2] Local selection 2 lets the serial connector write, start and set frequency.
// [RULE3] Under local selection 9999 serial traffic never makes the connector the source.
// [RULE4] Network and local selection both 2 keep local mode and refuse network.
// [RULE5] Changed selections take effect only at reset or soft reset.
// [RULE6] Modbus requests are refused in local mode.
// [RULE7] Panel mode indicators go dark unless the panel is the source.
// [RULE8] Without a fitted option, a switch to option-sourced network mode is refused.
// [RULE9] Local selection 9999 picks USB, then parameter unit, then panel.
// [RULE10] Network selection 9999 picks option if fitted, else the serial connector.
// [RULE11] Network selection 0 is option, 2 is connector, 9999 is automatic.
// [RULE12] Local selection 2 connector, 3 USB, 4 panel, 9999 automatic.
// [RULE13] Reads and monitoring are accepted from every port in every mode; the code refuses modbus reads in local mode.
// [RULE14] Privileged requests from ports other than the source are discarded.
`timescale 1ns/1ps
module cmdsel_top
    import cmdsel_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input cmdsel_pins_t pins_in,
    input cmdsel_req_t [NPORT-1:0] port_req,
    output logic [NPORT-1:0] port_accept,
    output logic [NPORT-1:0] port_reject,
    output logic [3:0] src_sel,
    output logic ind_local,
    output logic ind_net
);
    logic [31:0] cfg;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;
    logic [13:0] net_act;
    logic [13:0] loc_act;
    logic soft_rst;
    logic mode_req;
    logic mode_val;
    logic refused;
    cmdsel_mode_t state;
    cmdsel_pins_t pins;
    logic [3:0] src_res;
    logic [NPORT-1:0] mask;
    logic net_ok;
    logic [31:0] rd_mux;
    logic rd_hit;

    cmdsel_sync #(.W(3)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(pins_in),
        .q(pins)
    );

    cmdsel_resolve u_res (
        .net_sel(net_act),
        .loc_sel(loc_act),
        .in_net(state == ST_NET),
        .pins(pins),
        .src(src_res),
        .mask(mask),
        .net_ok(net_ok)
    );

    // Write address channel; address and data may come in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'h1;
            aw_addr <= 8'h00;
        end else if (awvalid && awready) begin
            awready <= 1'h0;
            aw_addr <= awaddr;
        end else if (bvalid && bready) begin
            awready <= 1'h1;
        end
    end

    // Write data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready <= 1'h1;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else if (wvalid && wready) begin
            wready <= 1'h0;
            w_data <= wdata;
            w_strb <= wstrb;
        end else if (bvalid && bready) begin
            wready <= 1'h1;
        end
    end

    // Both halves held and no response pending
    assign wr_go = !awready && !wready && !bvalid;

    // Write response, registered the cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'h0;
            bresp <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'h1;
            case (aw_addr)
                A_CFG, A_ACT, A_MODE, A_STAT, A_RST: bresp <= RESP_OKAY;
                default: bresp <= RESP_SLVERR;
            endcase
        end else if (bvalid && bready) begin
            bvalid <= 1'h0;
        end
    end

    // Pending selections, byte lanes honoured; ACT is read only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg <= {2'h0, LOC_SEL_RST, 2'h0, NET_SEL_RST};
        end else if (wr_go && aw_addr == A_CFG) begin
            for (int b = 0; b < 4; b++) begin
                if (w_strb[b]) begin
                    cfg[b*8 +: 8] <= w_data[b*8 +: 8];
                end
            end
        end
    end

    // One-cycle command strobes from MODE and RST writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_req <= 1'h0;
            mode_val <= 1'h0;
            soft_rst <= 1'h0;
        end else begin
            mode_req <= wr_go && aw_addr == A_MODE && w_strb[0];
            mode_val <= w_data[F_MODE_BIT];
            soft_rst <= wr_go && aw_addr == A_RST && w_strb[0] && w_data[F_APPLY_BIT];
        end
    end

    // Active selections move only on reset (see [RULE5])
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            net_act <= NET_SEL_RST;
            loc_act <= LOC_SEL_RST;
        end else if (soft_rst) begin
            net_act <= cfg[F_NET_LSB +: SEL_W];
            loc_act <= cfg[F_LOC_LSB +: SEL_W];
        end
    end

    // Operation mode; a refused switch stays in local mode (see [RULE4] [RULE8])
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_LOCAL;
            refused <= 1'h0;
        end else if (soft_rst) begin
            state <= ST_LOCAL;
            refused <= 1'h0;
        end else if (mode_req) begin
            unique case (state)
                ST_LOCAL: begin
                    if (mode_val && net_ok) begin
                        state <= ST_NET;
                        refused <= 1'h0;
                    end else if (mode_val) begin
                        refused <= 1'h1;
                    end
                end
                ST_NET: begin
                    if (!mode_val) begin
                        state <= ST_LOCAL;
                    end
                end
                default: state <= ST_LOCAL;
            endcase
        end
    end

    // Read mux; unmapped offsets read zero with an error response
    always_comb begin
        rd_mux = 32'h00000000;
        rd_hit = 1'h1;
        case (araddr)
            A_CFG: rd_mux = cfg;
            A_ACT: begin
                rd_mux[F_NET_LSB +: SEL_W] = net_act;
                rd_mux[F_LOC_LSB +: SEL_W] = loc_act;
            end
            A_MODE: begin
                rd_mux[F_MODE_BIT] = state == ST_NET;
                rd_mux[F_REFUSED_BIT] = refused;
            end
            A_STAT: begin
                rd_mux[3:0] = src_sel;
                rd_mux[F_OPT_BIT] = pins.opt;
                rd_mux[F_MASK_LSB +: NPORT] = mask;
            end
            A_RST: rd_mux = 32'h00000000;
            default: rd_hit = 1'h0;
        endcase
    end

    // Read channel, data one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'h1;
            rvalid <= 1'h0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'h0;
            rvalid <= 1'h1;
            rdata <= rd_mux;
            rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'h0;
            arready <= 1'h1;
        end
    end

    // Source select and panel indicators from one flop stage (see [RULE7])
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_sel <= SRC_PANEL;
            ind_local <= 1'h0;
            ind_net <= 1'h0;
        end else begin
            src_sel <= src_res; // see [RULE14]
            ind_local <= src_res == SRC_PANEL && state == ST_LOCAL;
            ind_net <= src_res == SRC_PANEL && state == ST_NET;
        end
    end

    // Per-port gating; reads pass always, modbus dies in local mode
    generate
        for (genvar i = 0; i < NPORT; i++) begin : g_port
            logic priv;
            logic ok;
            assign priv = port_req[i].kind == K_RUN || port_req[i].kind == K_STOP
                || port_req[i].kind == K_FREQ || port_req[i].kind == K_PWRITE;
            // Modbus reads are also dropped; the protocol is unusable here
            assign ok = !(port_req[i].modbus && state == ST_LOCAL) // see [RULE6]
                && (!priv || mask[i]); // see [RULE13] [RULE14]
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    port_accept[i] <= 1'h0;
                    port_reject[i] <= 1'h0;
                end else begin
                    port_accept[i] <= port_req[i].valid && ok;
                    port_reject[i] <= port_req[i].valid && !ok;
                end
            end
        end
    endgenerate

    property p_modbus_local;
        @(posedge aclk) disable iff (!aresetn)
        port_req[P_RS485].valid && port_req[P_RS485].modbus && state == ST_LOCAL
            |=> port_reject[P_RS485] && !port_accept[P_RS485];
    endproperty
    a_modbus_local: assert property (p_modbus_local) else $error("modbus taken locally"); // see [RULE6]

    property p_both_conn;
        @(posedge aclk) disable iff (!aresetn)
        mode_req && mode_val && state == ST_LOCAL && !soft_rst
            && net_act == SEL_CONN && loc_act == SEL_CONN
            |=> state == ST_LOCAL && refused;
    endproperty
    a_both_conn: assert property (p_both_conn) else $error("network switch not refused"); // see [RULE4]

    property p_no_option;
        @(posedge aclk) disable iff (!aresetn)
        mode_req && mode_val && !soft_rst && state == ST_LOCAL
            && net_act == SEL_OPT && !pins.opt |=> state == ST_LOCAL;
    endproperty
    a_no_option: assert property (p_no_option) else $error("switch without option"); // see [RULE8]

    property p_ind_dark;
        @(posedge aclk) disable iff (!aresetn)
        src_sel != SRC_PANEL |-> !ind_local && !ind_net;
    endproperty
    a_ind_dark: assert property (p_ind_dark) else $error("indicator lit off panel"); // see [RULE7]

    property p_apply_reset;
        @(posedge aclk) disable iff (!aresetn)
        !soft_rst ##1 1'h1 |-> $stable(net_act) && $stable(loc_act);
    endproperty
    a_apply_reset: assert property (p_apply_reset) else $error("selection moved early"); // see [RULE5]

    property p_read_any;
        @(posedge aclk) disable iff (!aresetn)
        port_req[P_USB].valid && !port_req[P_USB].modbus
            && port_req[P_USB].kind == K_MON |=> port_accept[P_USB];
    endproperty
    a_read_any: assert property (p_read_any) else $error("monitor refused"); // see [RULE13]

    property p_discard;
        @(posedge aclk) disable iff (!aresetn)
        port_req[P_PANEL].valid && port_req[P_PANEL].kind == K_RUN && !mask[P_PANEL]
            |=> port_reject[P_PANEL] ##1 1'h1;
    endproperty
    a_discard: assert property (p_discard) else $error("foreign run taken"); // see [RULE14]

    property p_usb_first;
        @(posedge aclk) disable iff (!aresetn)
        state == ST_LOCAL && loc_act == SEL_AUTO && pins.usb |=> src_sel == SRC_USB;
    endproperty
    a_usb_first: assert property (p_usb_first) else $error("usb not first"); // see [RULE9]

    property p_serial_auto;
        @(posedge aclk) disable iff (!aresetn)
        state == ST_LOCAL && loc_act == SEL_AUTO && port_req[P_RS485].valid
            && port_req[P_RS485].kind == K_FREQ |=> port_reject[P_RS485];
    endproperty
    a_serial_auto: assert property (p_serial_auto) else $error("serial took source"); // see [RULE3]

    property p_conn_local;
        @(posedge aclk) disable iff (!aresetn)
        state == ST_LOCAL && loc_act == SEL_CONN && port_req[P_RS485].valid
            && !port_req[P_RS485].modbus |=> port_accept[P_RS485];
    endproperty
    a_conn_local: assert property (p_conn_local) else $error("connector refused"); // see [RULE2]

    property p_net_auto;
        @(posedge aclk) disable iff (!aresetn)
        state == ST_NET && net_act == SEL_AUTO && !pins.opt |=> src_sel == SRC_CONN;
    endproperty
    a_net_auto: assert property (p_net_auto) else $error("auto network wrong"); // see [RULE10]
endmodule

// *** testbench.sv ***
/*
 * Self-checking bench: AXI4-Lite master tasks, command requests via the port model.
 * Assumes one 20 MHz clock and synchronous active-low reset.
 */
`timescale 1ns/1ps
module testbench
    import cmdsel_pkg::*;
;
    logic aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
    logic awready, wready, arready, ind_local, ind_net, go, modbus;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, src_sel;
    logic [1:0] bresp, rresp;
    logic [2:0] port, kind, fitted;
    logic [NPORT-1:0] port_accept, port_reject;
    cmdsel_req_t [NPORT-1:0] port_req;
    cmdsel_pins_t pins_in;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;

    cmdsel_top DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .pins_in, .port_req, .port_accept,
        .port_reject, .src_sel, .ind_local, .ind_net);
    cmdsel_ports_model u_ports (.aclk, .go, .port, .kind, .modbus, .fitted,
        .port_req, .pins(pins_in));

    // 50 ns clock
    initial begin
        aclk = 1'h0;
        forever #25 aclk = ~aclk;
    end

    task automatic summarize();
        if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Hang guard, far above the run length
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] cfg(input logic [13:0] network_operation_mode, input logic [13:0] loc);
        return {2'h0, loc, 2'h0, network_operation_mode};
    endfunction

    // Write: AW and W offered together, each dropped when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (t < 200) begin
            @(posedge aclk);
            t++;
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid && bready) begin
                bready <= 1'h0;
                chk(bresp, RESP_OKAY);
                t = 1000;
            end
        end
        if (t < 1000) chk(1'h0, 1'h1);
    endtask

    task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        int t;
        t = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (t < 200) begin
            @(posedge aclk);
            t++;
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid && rready) begin
                rready <= 1'h0;
                chk(rdata, exp);
                chk(rresp, er);
                t = 1000;
            end
        end
        if (t < 1000) chk(1'h0, 1'h1);
    endtask

    // One request; accept or reject is looked at in the cycle after it
    task automatic req(input int p, input logic [2:0] k, input logic mb, input logic acc);
        @(posedge aclk);
        go <= 1'h1;
        port <= 3'(p);
        kind <= k;
        modbus <= mb;
        @(posedge aclk);
        go <= 1'h0;
        @(posedge aclk);
        #1;
        chk({port_accept[p], port_reject[p]}, {acc, ~acc});
    endtask

    task automatic apply();
        axw(A_RST, 32'h00000001);
        repeat (3) @(posedge aclk);
    endtask

    task automatic setnet();
        axw(A_MODE, 32'h00000001);
        repeat (3) @(posedge aclk);
    endtask

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, go, modbus} = '0;
        {awaddr, araddr, wdata, wstrb, port, kind, fitted} = '0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        axr(A_CFG, cfg(SEL_AUTO, SEL_AUTO), RESP_OKAY);
        axr(A_ACT, cfg(SEL_AUTO, SEL_AUTO), RESP_OKAY);
        axr(A_MODE, 32'h0, RESP_OKAY);
        axr(8'h14, 32'h0, RESP_SLVERR);
        chk(src_sel, SRC_PANEL);
        chk(ind_local, 1'h1);
        req(P_PANEL, K_RUN, 1'h0, 1'h1);
        req(P_RS485, K_RUN, 1'h0, 1'h0);
        req(P_RS485, K_PREAD, 1'h0, 1'h1);
        req(P_USB, K_MON, 1'h0, 1'h1);
        req(P_PANEL, K_FREQ, 1'h1, 1'h0);
        // Parameter unit, then USB, attached under automatic choice
        @(posedge aclk) fitted <= 3'h1;
        repeat (4) @(posedge aclk);
        chk(src_sel, SRC_CONN);
        req(P_PUNIT, K_PWRITE, 1'h0, 1'h1);
        req(P_RS485, K_FREQ, 1'h0, 1'h0);
        @(posedge aclk) fitted <= 3'h3;
        repeat (4) @(posedge aclk);
        chk(src_sel, SRC_USB);
        chk({ind_local, ind_net}, 2'h0);
        req(P_USB, K_STOP, 1'h0, 1'h1);
        req(P_PANEL, K_RUN, 1'h0, 1'h0);
        // Both selections 2: latched only on apply, network refused
        axw(A_CFG, cfg(SEL_CONN, SEL_CONN));
        axr(A_ACT, cfg(SEL_AUTO, SEL_AUTO), RESP_OKAY);
        chk(src_sel, SRC_USB);
        apply();
        axr(A_ACT, cfg(SEL_CONN, SEL_CONN), RESP_OKAY);
        req(P_RS485, K_RUN, 1'h0, 1'h1);
        req(P_RS485, K_PWRITE, 1'h0, 1'h1);
        req(P_RS485, K_PREAD, 1'h1, 1'h0);
        req(P_PUNIT, K_FREQ, 1'h0, 1'h1);
        req(P_USB, K_RUN, 1'h0, 1'h0);
        setnet();
        axr(A_MODE, 32'h2, RESP_OKAY);
        // Option source without option fitted, then fitted
        @(posedge aclk) fitted <= 3'h0;
        axw(A_CFG, cfg(SEL_OPT, SEL_PANEL));
        apply();
        chk(src_sel, SRC_PANEL);
        req(P_PANEL, K_RUN, 1'h0, 1'h1);
        setnet();
        axr(A_MODE, 32'h2, RESP_OKAY);
        @(posedge aclk) fitted <= 3'h4;
        repeat (4) @(posedge aclk);
        axr(A_STAT, 32'h31, RESP_OKAY);
        setnet();
        axr(A_MODE, 32'h1, RESP_OKAY);
        chk(src_sel, SRC_NET);
        chk({ind_local, ind_net}, 2'h0);
        req(P_NET, K_RUN, 1'h1, 1'h1);
        req(P_PANEL, K_FREQ, 1'h0, 1'h0);
        req(P_PANEL, K_MON, 1'h0, 1'h1);
        // Back to local mode by request: panel takes over again
        axw(A_MODE, 32'h00000000);
        axr(A_MODE, 32'h0, RESP_OKAY);
        chk(src_sel, SRC_PANEL);
        chk(ind_local, 1'h1);
        // Automatic network choice with option removed
        @(posedge aclk) fitted <= 3'h0;
        axw(A_CFG, cfg(SEL_AUTO, SEL_USB));
        apply();
        axr(A_MODE, 32'h0, RESP_OKAY);
        chk(src_sel, SRC_USB);
        req(P_USB, K_RUN, 1'h0, 1'h1);
        setnet();
        chk(src_sel, SRC_CONN);
        req(P_RS485, K_FREQ, 1'h0, 1'h1);
        // Network selection 2 with USB local source
        axw(A_CFG, cfg(SEL_CONN, SEL_USB));
        apply();
        setnet();
        axr(A_MODE, 32'h1, RESP_OKAY);
        chk(src_sel, SRC_CONN);
        req(P_RS485, K_PWRITE, 1'h1, 1'h1);
        summarize();
    end
endmodule
